//--- verilog/osb_top.sv
// Packs oversampled records into cyclic blocks and drives the status LED.
// Assumes one 10 MHz clock, a network side that reads the shown block by
// sample and word index, and a sample source giving one record a pulse.
`timescale 1ns/1ps
`include "osb_defs.svh"

module osb_top
    import osb_pkg::*;
#(
    parameter int TICK_CYCLES = `OSB_TICK_CYC
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic cfg_load_in,
    input wire logic [`OSB_VALUES_PER_REC-1:0] cfg_sel_in,
    input wire logic [`OSB_SAMPLE_W-1:0] cfg_samples_in,
    input wire logic sample_valid_in,
    input wire logic [31:0] counter_in,
    input wire logic [31:0] tstamp_in,
    input wire logic [31:0] sensor_state_in,
    input wire logic [31:0] edges_in,
    input wire logic [31:0] pins_in,
    input wire logic [31:0] gaps_in,
    input wire logic [31:0] first_fall_in,
    input wire logic [31:0] stat_min_in,
    input wire logic [31:0] stat_max_in,
    input wire logic [127:0] extra_in,
    input wire logic [`OSB_SAMPLE_W-1:0] rd_sample_in,
    input wire logic [`OSB_WORD_W-1:0] rd_word_in,
    input wire osb_slave_state_t slave_state_in,
    input wire osb_error_t error_in,
    output logic [31:0] rd_data_out,
    output logic block_valid_out,
    output logic block_new_out,
    output logic [15:0] block_seq_out,
    output logic [`OSB_BYTES_W-1:0] block_bytes_out,
    output logic [`OSB_SAMPLE_W-1:0] block_samples_out,
    output logic led_green_out,
    output logic led_red_out
);

    localparam int NV = `OSB_VALUES_PER_REC;
    localparam int NS = `OSB_MAX_SAMPLES;

    function automatic logic [3:0] count_sel(
        input logic [NV-1:0] sel
    );
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < NV; i++) begin
            n = n + {3'h0, sel[i]};
        end
        return n;
    endfunction : count_sel

    // Selected fields move to the front, keeping the record order
    function automatic osb_rec_t pack_rec(
        input osb_rec_t raw,
        input logic [NV-1:0] sel
    );
        osb_rec_t p;
        logic [3:0] k;
        p = '0;
        k = 4'h0;
        for (int i = 0; i < NV; i++) begin
            if (sel[i]) begin
                p[k] = raw[i];
                k = k + 4'h1;
            end
        end
        return p;
    endfunction : pack_rec

    function automatic logic [`OSB_SAMPLE_W-1:0] clamp_samples(
        input logic [`OSB_SAMPLE_W-1:0] n
    );
        if (n == 5'h00) begin
            return 5'h01;
        end
        if (n > 5'(NS)) begin
            return 5'(NS);
        end
        return n;
    endfunction : clamp_samples

    function automatic logic [`OSB_BYTES_W-1:0] frame_bytes(
        input logic [`OSB_SAMPLE_W-1:0] ns,
        input logic [NV-1:0] sel
    );
        return `OSB_BYTES_W'(ns * count_sel(sel) * `OSB_BYTES_PER_VALUE);
    endfunction : frame_bytes

    // Configuration and filling state
    logic [NV-1:0] sel_q, sel_d;
    logic [`OSB_SAMPLE_W-1:0] nsamp_q, nsamp_d;
    logic [`OSB_SAMPLE_W-1:0] fill_q, fill_d;
    logic fbuf_q, fbuf_d;
    logic sbuf_q, sbuf_d;
    logic valid_q, valid_d;
    logic new_q, new_d;
    logic [15:0] seq_q, seq_d;
    logic [`OSB_BYTES_W-1:0] bytes_q, bytes_d;
    logic [`OSB_SAMPLE_W-1:0] shown_n_q, shown_n_d;
    logic [31:0] rd_q, rd_d;
    osb_rec_t mem_q [2][NS];
    osb_rec_t mem_d [2][NS];
    osb_rec_t raw_rec;
    osb_rec_t packed_rec;
    logic done;

    assign raw_rec = {extra_in, stat_max_in, stat_min_in, first_fall_in,
                      gaps_in, pins_in, edges_in, sensor_state_in,
                      tstamp_in, counter_in};
    assign packed_rec = pack_rec(raw_rec, sel_q);
    assign done = sample_valid_in && !cfg_load_in
                  && (fill_q == nsamp_q - 5'h01);

    always_comb begin
        sel_d = sel_q;
        nsamp_d = nsamp_q;
        fill_d = fill_q;
        fbuf_d = fbuf_q;
        sbuf_d = sbuf_q;
        valid_d = valid_q;
        new_d = 1'b0;
        seq_d = seq_q;
        bytes_d = bytes_q;
        shown_n_d = shown_n_q;
        mem_d = mem_q;
        if (cfg_load_in) begin
            // A new layout restarts the block being filled
            sel_d = cfg_sel_in;
            nsamp_d = clamp_samples(cfg_samples_in);
            fill_d = '0;
        end else if (sample_valid_in) begin
            mem_d[fbuf_q][fill_q] = packed_rec;
            if (done) begin
                // Swap even if the shown block was never fetched
                fill_d = '0;
                fbuf_d = !fbuf_q;
                sbuf_d = fbuf_q;
                valid_d = 1'b1;
                new_d = 1'b1;
                seq_d = seq_q + 16'h0001;
                bytes_d = frame_bytes(nsamp_q, sel_q);
                shown_n_d = nsamp_q;
            end else begin
                fill_d = fill_q + 5'h01;
            end
        end
        rd_d = 32'h0000_0000;
        if (valid_q && rd_sample_in < shown_n_q && rd_word_in < 4'(NV)) begin
            rd_d = mem_q[sbuf_q][rd_sample_in][rd_word_in];
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sel_q <= `OSB_SEL_DEFAULT;
            nsamp_q <= `OSB_SAMPLES_DEFAULT;
            fill_q <= '0;
            fbuf_q <= 1'b0;
            sbuf_q <= 1'b1;
            valid_q <= 1'b0;
            new_q <= 1'b0;
            seq_q <= 16'h0000;
            bytes_q <= '0;
            shown_n_q <= '0;
            rd_q <= 32'h0000_0000;
            mem_q <= '{default: '0};
        end else begin
            sel_q <= sel_d;
            nsamp_q <= nsamp_d;
            fill_q <= fill_d;
            fbuf_q <= fbuf_d;
            sbuf_q <= sbuf_d;
            valid_q <= valid_d;
            new_q <= new_d;
            seq_q <= seq_d;
            bytes_q <= bytes_d;
            shown_n_q <= shown_n_d;
            rd_q <= rd_d;
            mem_q <= mem_d;
        end
    end

    assign rd_data_out = rd_q;
    assign block_valid_out = valid_q;
    assign block_new_out = new_q;
    assign block_seq_out = seq_q;
    assign block_bytes_out = bytes_q;
    assign block_samples_out = shown_n_q;

    // Indicator: one tick drives one phase counter shared by all patterns
    logic [`OSB_PRESC_W-1:0] presc_q, presc_d;
    logic [`OSB_PHASE_W-1:0] phase_q, phase_d;
    logic green_q, green_d;
    logic red_q, red_d;
    logic tick;
    logic g_pat, r_pat;
    logic [`OSB_PHASE_W-1:0] ph_single, ph_double, ph_slow, ph_fast;

    assign tick = (presc_q == `OSB_PRESC_W'(TICK_CYCLES - 1));
    assign ph_single = phase_q % `OSB_PHASE_W'(`OSB_SINGLE_T);
    assign ph_double = phase_q % `OSB_PHASE_W'(`OSB_DOUBLE_T);
    assign ph_slow = phase_q % `OSB_PHASE_W'(2 * `OSB_SLOW_HALF_T);
    assign ph_fast = phase_q % `OSB_PHASE_W'(2 * `OSB_FAST_HALF_T);

    always_comb begin
        presc_d = tick ? '0 : presc_q + `OSB_PRESC_W'(1);
        phase_d = phase_q;
        if (tick) begin
            phase_d = (phase_q == `OSB_PHASE_W'(`OSB_PHASE_WRAP - 1))
                      ? '0 : phase_q + `OSB_PHASE_W'(1);
        end
        unique case (slave_state_in)
            OSB_ST_INIT: g_pat = 1'b0;
            OSB_ST_PREOP: g_pat = ph_slow < `OSB_PHASE_W'(`OSB_SLOW_HALF_T);
            OSB_ST_SAFEOP: g_pat = ph_single < `OSB_PHASE_W'(`OSB_ON_T);
            OSB_ST_OP: g_pat = 1'b1;
        endcase
        unique case (error_in)
            OSB_ERR_NONE: r_pat = 1'b0;
            OSB_ERR_BAD_CFG: r_pat = ph_slow < `OSB_PHASE_W'(`OSB_SLOW_HALF_T);
            OSB_ERR_UNREQ_CHANGE: r_pat = ph_single < `OSB_PHASE_W'(`OSB_ON_T);
            OSB_ERR_WATCHDOG: begin
                r_pat = ph_double < `OSB_PHASE_W'(`OSB_ON_T)
                        || (ph_double >= `OSB_PHASE_W'(2 * `OSB_ON_T)
                        && ph_double < `OSB_PHASE_W'(3 * `OSB_ON_T));
            end
            OSB_ERR_INIT: r_pat = ph_fast < `OSB_PHASE_W'(`OSB_FAST_HALF_T);
            default: r_pat = 1'b0;
        endcase
        green_d = g_pat;
        red_d = r_pat && !g_pat;
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            presc_q <= '0;
            phase_q <= '0;
            green_q <= 1'b0;
            red_q <= 1'b0;
        end else begin
            presc_q <= presc_d;
            phase_q <= phase_d;
            green_q <= green_d;
            red_q <= red_d;
        end
    end

    assign led_green_out = green_q;
    assign led_red_out = red_q;

    // Checks
    logic cfg_seen_q;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_seen_q <= 1'b0;
        end else if (cfg_load_in) begin
            cfg_seen_q <= 1'b1;
        end
    end

    sequence s_last_sample;
        sample_valid_in && !cfg_load_in && fill_q == nsamp_q - 5'h01;
    endsequence
    sequence s_swapped(logic b);
        sbuf_q == b && valid_q && new_q;
    endsequence

    block_swap_a: assert property (@(posedge clk_in)
        disable iff (!resetn_in) s_last_sample |=> s_swapped($past(fbuf_q)))
        else $error("completed block not presented");
    block_hold_a: assert property (@(posedge clk_in)
        disable iff (!resetn_in) !done
        |=> $stable(sbuf_q) && $stable(seq_q) && !new_q)
        else $error("shown block changed before completion");
    replace_seq_a: assert property (@(posedge clk_in)
        disable iff (!resetn_in) done |=> seq_q == $past(seq_q) + 16'h0001)
        else $error("block sequence did not advance");

    frame_size_a: assert property (@(posedge clk_in)
        disable iff (!resetn_in) done |=> bytes_q == `OSB_BYTES_W'(
            $past(nsamp_q) * count_sel($past(sel_q)) * 4))
        else $error("frame byte count wrong");

    fill_limit_a: assert property (@(posedge clk_in)
        disable iff (!resetn_in) fill_q < nsamp_q && nsamp_q != 5'h00)
        else $error("fill index beyond sample count");

    record_order_a: assert property (@(posedge clk_in)
        disable iff (!resetn_in) sel_q[1:0] == 2'b11
        |-> packed_rec[0] == counter_in && packed_rec[1] == tstamp_in)
        else $error("record field order wrong");

    default_sel_a: assert property (@(posedge clk_in)
        disable iff (!resetn_in) !cfg_seen_q |-> sel_q == `OSB_SEL_DEFAULT)
        else $error("default selection lost");

    led_exclusive_a: assert property (@(posedge clk_in)
        disable iff (!resetn_in) !(led_green_out && led_red_out))
        else $error("red shown during green on time");

    green_init_a: assert property (@(posedge clk_in)
        disable iff (!resetn_in) slave_state_in == OSB_ST_INIT
        |=> !led_green_out)
        else $error("green lit in init");

    green_op_a: assert property (@(posedge clk_in)
        disable iff (!resetn_in) slave_state_in == OSB_ST_OP |=> led_green_out)
        else $error("green not steady in op");

    phase_tick_a: assert property (@(posedge clk_in)
        disable iff (!resetn_in) !tick |=> $stable(phase_q))
        else $error("phase moved without tick");

    red_watchdog_a: assert property (@(posedge clk_in)
        disable iff (!resetn_in) error_in == OSB_ERR_WATCHDOG
        && slave_state_in == OSB_ST_INIT
        && ph_double >= `OSB_PHASE_W'(3 * `OSB_ON_T) |=> !led_red_out)
        else $error("red lit in double flash gap");

endmodule : osb_top

//--- verilog/osb_defs.svh
// Constants of the oversample block framer and the status indicator.
// Assumes a 10 MHz device clock; included by osb_pkg and osb_top.
`ifndef OSB_DEFS_SVH
`define OSB_DEFS_SVH

`define OSB_VALUES_PER_REC 13
`define OSB_BYTES_PER_VALUE 4
`define OSB_MAX_SAMPLES 25
`define OSB_SAMPLE_W 5
`define OSB_WORD_W 4
`define OSB_BYTES_W 11

// Field positions inside one sample record
`define OSB_F_COUNTER 0
`define OSB_F_TSTAMP 1
`define OSB_F_STATE 2
`define OSB_F_EDGES 3
`define OSB_F_PINS 4
`define OSB_F_GAPS 5
`define OSB_F_FIRST_FALL 6
`define OSB_F_MIN 7
`define OSB_F_MAX 8
`define OSB_F_EXTRA 9

// Reset configuration: first falling edge only, one sample per block
`define OSB_SEL_DEFAULT 13'h0040
`define OSB_SAMPLES_DEFAULT 5'h01

// Indicator timing
`define OSB_CLK_PERIOD_NS 100
`define OSB_TICK_MS 50
`define OSB_TICK_CYC (`OSB_TICK_MS * 1000000 / `OSB_CLK_PERIOD_NS)
`define OSB_FLASH_ON_MS 200
`define OSB_SINGLE_OFF_MS 1000
`define OSB_DOUBLE_GAP_MS 400
`define OSB_BLINK_SLOW_HALF_MS 200
`define OSB_BLINK_FAST_HALF_MS 50
`define OSB_ON_T (`OSB_FLASH_ON_MS / `OSB_TICK_MS)
`define OSB_SINGLE_T ((`OSB_FLASH_ON_MS + `OSB_SINGLE_OFF_MS) / `OSB_TICK_MS)
`define OSB_DOUBLE_T (3 * `OSB_ON_T + `OSB_DOUBLE_GAP_MS / `OSB_TICK_MS)
`define OSB_SLOW_HALF_T (`OSB_BLINK_SLOW_HALF_MS / `OSB_TICK_MS)
`define OSB_FAST_HALF_T (`OSB_BLINK_FAST_HALF_MS / `OSB_TICK_MS)
`define OSB_PHASE_WRAP 120
`define OSB_PRESC_W 20
`define OSB_PHASE_W 7

`endif

//--- verilog/osb_pkg.sv
// Types of the oversample block framer and the status indicator.
// Assumes osb_defs.svh for the values per record; enum and word widths are set here.
`include "osb_defs.svh"

package osb_pkg;

    typedef enum logic [1:0] {
        OSB_ST_INIT,
        OSB_ST_PREOP,
        OSB_ST_SAFEOP,
        OSB_ST_OP
    } osb_slave_state_t;

    typedef enum logic [2:0] {
        OSB_ERR_NONE,
        OSB_ERR_BAD_CFG,
        OSB_ERR_UNREQ_CHANGE,
        OSB_ERR_WATCHDOG,
        OSB_ERR_INIT
    } osb_error_t;

    typedef logic [`OSB_VALUES_PER_REC-1:0][31:0] osb_rec_t;

endpackage : osb_pkg

//--- test/osb_master_model.sv
// Polling master model: reads the shown block by sample and word index.
// Assumes osb_top gives read data one edge after the index is taken.
`timescale 1ns/1ps
`include "osb_defs.svh"

module osb_master_model (
    input wire logic clk_in,
    input wire logic [31:0] rd_data_in,
    input wire logic [15:0] block_seq_in,
    output logic [`OSB_SAMPLE_W-1:0] rd_sample_out,
    output logic [`OSB_WORD_W-1:0] rd_word_out
);
    logic [31:0] last_cnt;

    initial begin
        rd_sample_out = '0;
        rd_word_out = '0;
        last_cnt = 32'hffff_ffff;
    end

    // One spare edge on top of the read latency costs little and hides nothing
    task automatic read(input int s, input int w, output logic [31:0] d);
        @(posedge clk_in);
        rd_sample_out <= s[`OSB_SAMPLE_W-1:0];
        rd_word_out <= w[`OSB_WORD_W-1:0];
        repeat (2) @(posedge clk_in);
        #1;
        d = rd_data_in;
    endtask : read

    // Gap sets how slow the master cycle is
    task automatic poll(input int gap, output logic [15:0] seq,
            output logic [31:0] d, output logic rep);
        repeat (gap) @(posedge clk_in);
        read(0, 0, d);
        seq = block_seq_in;
        rep = (d === last_cnt);
        last_cnt = d;
    endtask : poll
endmodule : osb_master_model

//--- test/oversample_block_and_status_led_test.sv
// Testbench of osb_top: block framing, block handover, status LED.
// Assumes osb_master_model as the polling side and a short LED tick.
`timescale 1ns/1ps
`include "osb_defs.svh"

module oversample_block_and_status_led_test;
    import osb_pkg::*;
    localparam int TICK = 10;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic cfg_load_in = 1'b0;
    logic [12:0] cfg_sel_in = 13'h0040;
    logic [4:0] cfg_samples_in = 5'h01;
    logic sample_valid_in = 1'b0;
    logic [31:0] b = 32'h0;
    osb_slave_state_t st = OSB_ST_INIT;
    osb_error_t er = OSB_ERR_NONE;
    logic [4:0] rs;
    logic [3:0] rw;
    logic [31:0] rd;
    logic bv, bn, g, r;
    logic [15:0] seq;
    logic [10:0] bytes;
    logic [4:0] nsamp;
    int failures = 0;
    int n_checks = 0;
    int n_new = 0;

    osb_top #(.TICK_CYCLES(TICK)) uut (
        .clk_in(clk_in), .resetn_in(resetn_in), .cfg_load_in(cfg_load_in),
        .cfg_sel_in(cfg_sel_in), .cfg_samples_in(cfg_samples_in),
        .sample_valid_in(sample_valid_in), .counter_in(b),
        .tstamp_in(b + 32'h1), .sensor_state_in(b + 32'h2),
        .edges_in(b + 32'h3), .pins_in(b + 32'h4), .gaps_in(b + 32'h5),
        .first_fall_in(b + 32'h6), .stat_min_in(b + 32'h7),
        .stat_max_in(b + 32'h8),
        .extra_in({b + 32'hc, b + 32'hb, b + 32'ha, b + 32'h9}),
        .rd_sample_in(rs), .rd_word_in(rw), .slave_state_in(st),
        .error_in(er), .rd_data_out(rd), .block_valid_out(bv),
        .block_new_out(bn), .block_seq_out(seq), .block_bytes_out(bytes),
        .block_samples_out(nsamp), .led_green_out(g), .led_red_out(r));

    osb_master_model m (.clk_in(clk_in), .rd_data_in(rd),
        .block_seq_in(seq), .rd_sample_out(rs), .rd_word_out(rw));

    initial begin
        forever #50 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        if (bn === 1'b1) n_new++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("Checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    task automatic cfg(input logic [12:0] sel, input logic [4:0] n);
        @(posedge clk_in);
        cfg_load_in <= 1'b1;
        cfg_sel_in <= sel;
        cfg_samples_in <= n;
        @(posedge clk_in);
        cfg_load_in <= 1'b0;
        #1;
    endtask : cfg

    // Records back to back; record i carries base + i * 0x100 + field
    task automatic push(input int n, input logic [31:0] base);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            sample_valid_in <= 1'b1;
            b <= base + 32'(i) * 32'h100;
        end
        @(posedge clk_in);
        sample_valid_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        #1;
    endtask : push

    task automatic t_default();
        logic [31:0] d;
        check(32'(bv), 32'h0);
        push(1, 32'h1000);
        check(32'(bv), 32'h1);
        check(32'(n_new), 32'h1);
        check(32'(bytes), 32'h4);
        m.read(0, 0, d);
        check(d, 32'h1006);
        m.read(0, 1, d);
        check(d, 32'h0);
    endtask : t_default

    task automatic t_layout();
        logic [31:0] d;
        cfg(13'h1fff, 5'h0a);
        push(9, 32'h2000);
        check(32'(n_new), 32'h1);
        check(32'(bytes), 32'h4);
        push(1, 32'h2900);
        check(32'(n_new), 32'h2);
        check(32'(bytes), 32'd520);
        check(32'(nsamp), 32'd10);
        for (int w = 0; w < 13; w++) begin
            m.read(3, w, d);
            check(d, 32'h2300 + 32'(w));
        end
        m.read(9, 12, d);
        check(d, 32'h290c);
        cfg(13'h0182, 5'h01);
        push(1, 32'h3000);
        check(32'(bytes), 32'd12);
        for (int w = 0; w < 3; w++) begin
            m.read(0, w, d);
            check(d, (w == 0) ? 32'h3001 : 32'h3006 + 32'(w));
        end
    endtask : t_layout

    task automatic t_replace();
        logic [31:0] d;
        logic [15:0] s0;
        logic [15:0] s1;
        logic rep;
        cfg(13'h0001, 5'h02);
        s0 = seq;
        push(6, 32'h4000);
        m.poll(0, s1, d, rep);
        check(32'(16'(s1 - s0)), 32'h3);
        check(d, 32'h4400);
        m.read(1, 0, d);
        check(d, 32'h4500);
    endtask : t_replace

    // Master polls faster than a block fills, so blocks repeat
    task automatic t_repeat();
        logic [31:0] d;
        logic [15:0] s0;
        logic [15:0] s1;
        logic rep;
        m.poll(20, s0, d, rep);
        m.poll(20, s1, d, rep);
        check(32'(rep), 32'h1);
        check(32'(s1), 32'(s0));
        check(d, 32'h4400);
        push(2, 32'h5000);
        m.poll(0, s1, d, rep);
        check(32'(rep), 32'h0);
        check(d, 32'h5000);
    endtask : t_repeat

    // Out-of-range sample counts fall back to one and to the maximum
    task automatic t_clamp();
        logic [31:0] d;
        cfg(13'h0040, 5'h00);
        push(1, 32'h6000);
        check(32'(nsamp), 32'h1);
        cfg(13'h0040, 5'h1f);
        push(25, 32'h7000);
        check(32'(nsamp), 32'd25);
        check(32'(bytes), 32'd100);
        m.read(24, 0, d);
        check(d, 32'h8806);
    endtask : t_clamp

    // Reset in mid-run drops the shown block and restores the default layout
    task automatic t_reset();
        logic [31:0] d;
        @(posedge clk_in);
        resetn_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        @(posedge clk_in);
        #1;
        check(32'(bv), 32'h0);
        check(32'(seq), 32'h0);
        check(32'(nsamp), 32'h0);
        push(1, 32'h9000);
        check(32'(bv), 32'h1);
        check(32'(seq), 32'h1);
        check(32'(bytes), 32'h4);
        m.read(0, 0, d);
        check(d, 32'h9006);
    endtask : t_reset

    // Counts lit cycles and longest runs over one full phase counter wrap of 120 ticks
    task automatic led(input osb_slave_state_t s, input osb_error_t e,
            input int eg, input int enr, input int rg, input int rr);
        int ng = 0, nr = 0, cg = 0, cr = 0, mg = 0, mr = 0, both = 0;
        @(posedge clk_in);
        st <= s;
        er <= e;
        repeat (3) @(posedge clk_in);
        for (int i = 0; i < 120 * TICK; i++) begin
            @(posedge clk_in);
            #1;
            cg = (g === 1'b1) ? cg + 1 : 0;
            cr = (r === 1'b1) ? cr + 1 : 0;
            ng += (g === 1'b1);
            nr += (r === 1'b1);
            both += (g === 1'b1 && r === 1'b1);
            mg = (cg > mg) ? cg : mg;
            mr = (cr > mr) ? cr : mr;
        end
        check(ng, eg);
        check(nr, enr);
        check(mg, rg);
        check(mr, rr);
        check(both, 0);
    endtask : led

    initial begin
        repeat (20) @(posedge clk_in);
        resetn_in <= 1'b1;
        @(posedge clk_in);
        t_default();
        t_layout();
        t_replace();
        t_repeat();
        t_clamp();
        t_reset();
        led(OSB_ST_INIT, OSB_ERR_NONE, 0, 0, 0, 0);
        led(OSB_ST_PREOP, OSB_ERR_NONE, 60 * TICK, 0, 4 * TICK, 0);
        led(OSB_ST_SAFEOP, OSB_ERR_NONE, 20 * TICK, 0, 4 * TICK, 0);
        led(OSB_ST_OP, OSB_ERR_NONE, 120 * TICK, 0, 120 * TICK, 0);
        led(OSB_ST_INIT, OSB_ERR_BAD_CFG, 0, 60 * TICK, 0, 4 * TICK);
        led(OSB_ST_INIT, OSB_ERR_UNREQ_CHANGE, 0, 20 * TICK, 0, 4 * TICK);
        led(OSB_ST_INIT, OSB_ERR_INIT, 0, 60 * TICK, 0, TICK);
        led(OSB_ST_INIT, OSB_ERR_WATCHDOG, 0, 48 * TICK, 0, 4 * TICK);
        led(OSB_ST_OP, OSB_ERR_WATCHDOG, 120 * TICK, 0, 120 * TICK, 0);
        led(OSB_ST_PREOP, OSB_ERR_INIT, 60 * TICK, 30 * TICK, 4 * TICK, TICK);
        finish_test();
    end

    initial begin
        repeat (40000) @(posedge clk_in);
        failures++;
        finish_test();
    end
endmodule : oversample_block_and_status_led_test
